/* File: verilog/timer_defs.svh */
// Register map, reset values and counts of the reloadable timer
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define TMR_CTRL_OFS     8'h00
`define TMR_COUNT_OFS    8'h04
`define TMR_RELOAD_OFS   8'h08
`define TMR_STATUS_OFS   8'h0C
`define TMR_CTRL_RST     8'h00
`define TMR_COUNT_RST    16'h0001
`define TMR_RELOAD_RST   16'h0000
`define TMR_RESTART      16'h0001
`define TMR_COUNT_MAX    16'hFFFF
`define TMR_PRE_MAX_EXP  3'h7

`endif

/* File: verilog/timer_pkg.sv */
// Types shared by the reloadable timer
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_ONESHOT = 2'h0,
    MODE_CONT    = 2'h1,
    MODE_COUNTER = 2'h2,
    MODE_RSVD    = 2'h3
  } mode_t;

  // Control register layout, bit 0 at the bottom
  typedef struct packed {
    logic       out_en;
    logic       timer_polarity;
    logic [2:0] prescale;
    mode_t      mode;
    logic       enable;
  } ctrl_t;

  // Bus data-phase record
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
  } bus_phase_t;

endpackage : timer_pkg

/* File: verilog/reloadable_timer_16bit.sv */
// Reloadable 16-bit timer with AHB-Lite register slave
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "timer_defs.svh"

module reloadable_timer_16bit
  import timer_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        timer_in_pin_in,
  output logic             timer_out_pin_out,
  output logic             irq_out
);

  ctrl_t       ctrl_r;
  logic [15:0] count_r;
  logic [15:0] reload_r;
  logic        at_reload_r;
  logic [6:0]  pre_cnt_r;
  logic        tin_meta_r;
  logic        tin_sync_r;
  logic        tin_prev_r;
  logic        irq_r;
  logic        toggle_r;
  logic        pulse_r;
  logic        out_r;
  logic [31:0] hrdata_r;
  bus_phase_t  dp_r;
  bus_phase_t  dp_nxt;

  logic        addr_ok;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_reload;
  logic        oneshot;
  logic        counter_mode;
  logic        pre_hit;
  logic        edge_hit;
  logic        tick;
  logic [15:0] cnt_nxt;
  logic        match;
  logic [31:0] rd_mux;

  function automatic logic [6:0] pre_limit(input logic [2:0] e);
    logic [7:0] d;
    d = (8'h01 << e) - 8'h01;
    return d[6:0];
  endfunction : pre_limit

  // Bus decode
  assign addr_ok   = hsel_in & htrans_in[1] & hready_in;
  assign wr_ctrl   = dp_r.wr & (dp_r.addr == `TMR_CTRL_OFS);
  assign wr_count  = dp_r.wr & (dp_r.addr == `TMR_COUNT_OFS);
  assign wr_reload = dp_r.wr & (dp_r.addr == `TMR_RELOAD_OFS);

  always_comb
  begin
    dp_nxt.wr   = addr_ok & hwrite_in;
    dp_nxt.rd   = addr_ok & ~hwrite_in;
    dp_nxt.addr = haddr_in[7:0];
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      dp_r <= '0;
    else
      dp_r <= dp_nxt;
  end

  always_comb
  begin
    case (dp_r.addr)
      `TMR_CTRL_OFS:   rd_mux = {24'h000000, ctrl_r};
      `TMR_COUNT_OFS:  rd_mux = {16'h0000, count_r};
      `TMR_RELOAD_OFS: rd_mux = {16'h0000, reload_r};
      `TMR_STATUS_OFS: rd_mux = {28'h0000000, out_r, tin_sync_r, at_reload_r, ctrl_r.enable};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // Reads take one wait state so data comes from a flop
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      hrdata_r <= 32'h00000000;
    else if (dp_r.rd)
      hrdata_r <= rd_mux;
  end

  assign hrdata_out    = hrdata_r;
  assign hreadyout_out = ~dp_r.rd;
  assign hresp_out     = 1'b0;

  // Timer input synchroniser and edge detect
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tin_meta_r <= 1'b0;
      tin_sync_r <= 1'b0;
      tin_prev_r <= 1'b0;
    end
    else
    begin
      tin_meta_r <= timer_in_pin_in;
      tin_sync_r <= tin_meta_r;
      tin_prev_r <= tin_sync_r;
    end
  end

  assign edge_hit = ctrl_r.timer_polarity ? (tin_sync_r & ~tin_prev_r)
                                          : (~tin_sync_r & tin_prev_r);

  assign oneshot      = (ctrl_r.mode == MODE_ONESHOT);
  assign counter_mode = (ctrl_r.mode == MODE_COUNTER);
  assign pre_hit      = (pre_cnt_r == pre_limit(ctrl_r.prescale));
  assign tick         = ctrl_r.enable & (counter_mode ? edge_hit : pre_hit);
  assign cnt_nxt      = at_reload_r ? `TMR_RESTART : count_r + 16'h0001;
  assign match        = tick & (cnt_nxt == reload_r);

  // Prescaler
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      pre_cnt_r <= 7'h00;
    else if (!ctrl_r.enable || counter_mode || pre_hit)
      pre_cnt_r <= 7'h00;
    else
      pre_cnt_r <= pre_cnt_r + 7'h01;
  end

  // Control register, one-shot clears its own enable
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      ctrl_r <= ctrl_t'(`TMR_CTRL_RST);
    else if (wr_ctrl)
      ctrl_r <= ctrl_t'(hwdata_in[7:0]);
    else if (match && oneshot)
      ctrl_r.enable <= 1'b0;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      reload_r <= `TMR_RELOAD_RST;
    else if (wr_reload)
      reload_r <= hwdata_in[15:0];
  end

  // Count: sits at reload one tick, then restarts at one; one-shot goes straight to one at the match
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      count_r     <= `TMR_COUNT_RST;
      at_reload_r <= 1'b0;
    end
    else if (wr_count)
    begin
      count_r     <= hwdata_in[15:0];
      at_reload_r <= 1'b0;
    end
    else if (tick)
    begin
      count_r     <= (match && oneshot) ? `TMR_RESTART : cnt_nxt;
      at_reload_r <= match & ~oneshot;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      irq_r <= 1'b0;
    else
      irq_r <= match;
  end

  // Output: polarity, lasting toggle, one-shot pulse
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      toggle_r <= 1'b0;
    else if (wr_ctrl && !hwdata_in[0])
      toggle_r <= 1'b0;
    else if (match && !oneshot && ctrl_r.out_en)
      toggle_r <= ~toggle_r;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      pulse_r <= 1'b0;
    else
      pulse_r <= match & oneshot & ctrl_r.out_en;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      out_r <= 1'b0;
    else
      out_r <= ctrl_r.timer_polarity ^ toggle_r ^ pulse_r;
  end

  assign timer_out_pin_out = out_r;
  assign irq_out           = irq_r;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  AST_WRAP: assert property (
    (tick && !at_reload_r && count_r == `TMR_COUNT_MAX && !match && !wr_count)
      |=> (count_r == 16'h0000))
    else $error("count did not wrap to zero");

  AST_PRESCALE: assert property (
    (tick && !counter_mode && ctrl_r.prescale == `TMR_PRE_MAX_EXP && !wr_ctrl)
      |=> (!tick) [*8])
    else $error("prescale 128 ticked too soon");

  AST_ONESHOT_STOP: assert property (
    (match && oneshot && !wr_ctrl && !wr_count)
      |=> (!ctrl_r.enable && count_r == `TMR_RESTART))
    else $error("one-shot did not stop at one");

  AST_PULSE: assert property (
    (match && oneshot && ctrl_r.out_en && !wr_ctrl)
      |=> pulse_r ##1 (!pulse_r && out_r != $past(ctrl_r.timer_polarity)))
    else $error("one-shot output pulse wrong");

  AST_RESTART: assert property (
    (tick && at_reload_r && !wr_count && !wr_ctrl)
      |=> (count_r == `TMR_RESTART && ctrl_r.enable))
    else $error("continuous restart not at one");

  AST_TOGGLE: assert property (
    (match && !oneshot && ctrl_r.out_en && !wr_ctrl)
      |=> (toggle_r != $past(toggle_r)) ##1 (out_r == (ctrl_r.timer_polarity ^ $past(toggle_r))))
    else $error("output did not toggle on reload");

  AST_COUNTER_EDGE: assert property (
    (ctrl_r.enable && counter_mode && edge_hit && !at_reload_r && !match && !wr_count)
      |=> (count_r == $past(count_r) + 16'h0001))
    else $error("counter edge did not advance count by one");

  AST_IRQ: assert property (
    match |=> irq_out ##0 (irq_out == $past(match)))
    else $error("interrupt not raised after match");

  AST_IRQ_QUIET: assert property (
    !tick |=> !irq_out)
    else $error("interrupt without advance");

  COV_ONESHOT: cover property (match && oneshot);
  COV_CONT:    cover property (match && ctrl_r.mode == MODE_CONT ##[1:1000] match);
  COV_COUNTER: cover property (match && counter_mode);

endmodule : reloadable_timer_16bit

/* File: bench/test_reloadable_timer_16bit.sv */
// Self-checking testbench for the reloadable timer
`timescale 1ns/1ps
module test_reloadable_timer_16bit;
  import timer_pkg::*;
  logic        ref_clk_in      = 1'b0;
  logic        resetn_in       = 1'b0;
  logic        hsel_in         = 1'b0;
  logic [31:0] haddr_in        = 32'h0;
  logic [1:0]  htrans_in       = 2'h0;
  logic        hwrite_in       = 1'b0;
  logic [31:0] hwdata_in       = 32'h0;
  logic        timer_in_pin_in = 1'b0;
  logic [31:0] hrdata_out;
  logic        hreadyout_out;
  logic        hresp_out;
  logic        timer_out_pin_out;
  logic        irq_out;
  logic [31:0] d;
  logic        o0;
  logic        o1;
  int          num_errors = 0;
  int          compares   = 0;
  int          cyc        = 0;
  int          nirq       = 0;
  int          ts;
  int          t0;
  int          t1;
  int          base;
  int          k;
  int          pes[3]     = '{0, 3, 7};

  reloadable_timer_16bit i_reloadable_timer_16bit (
    .ref_clk_in       (ref_clk_in),
    .resetn_in        (resetn_in),
    .hsel_in          (hsel_in),
    .haddr_in         (haddr_in),
    .htrans_in        (htrans_in),
    .hwrite_in        (hwrite_in),
    .hsize_in         (3'h2),
    .hwdata_in        (hwdata_in),
    .hready_in        (hreadyout_out),
    .hrdata_out       (hrdata_out),
    .hreadyout_out    (hreadyout_out),
    .hresp_out        (hresp_out),
    .timer_in_pin_in  (timer_in_pin_in),
    .timer_out_pin_out(timer_out_pin_out),
    .irq_out          (irq_out)
  );

  always #2.5 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (irq_out === 1'b1)
      nirq <= nirq + 1;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task check(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // One bus phase: waits for hready high at a rising edge
  task bus_wait(output logic [31:0] r);
    int   n;
    logic rdy;
    n = 0;
    do
    begin
      @(negedge ref_clk_in);
      rdy = hreadyout_out;
      r = hrdata_out;
      n++;
      if (n > 20)
      begin
        num_errors++;
        report_and_stop;
      end
      @(posedge ref_clk_in);
    end
    while (rdy !== 1'b1);
  endtask : bus_wait

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel_in   <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in  <= {24'h0, a};
    hwrite_in <= w;
    bus_wait(d);
    hsel_in   <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    bus_wait(d);
  endtask : xfer

  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(n, e, d);
    check("response", 32'h0, hresp_out);
  endtask : rchk

  // Configure disabled, load count and reload, then enable
  task run(input logic oe, pol, input logic [2:0] e, input logic [1:0] m,
           input logic [15:0] st, rl);
    xfer(1'b1, 8'h00, {24'h0, oe, pol, e, m, 1'b0});
    xfer(1'b1, 8'h04, {16'h0, st});
    xfer(1'b1, 8'h08, {16'h0, rl});
    xfer(1'b1, 8'h00, {24'h0, oe, pol, e, m, 1'b1});
    ts = cyc;
  endtask : run

  task wait_irq(output int t, output logic o);
    int n;
    for (n = 0; n < 2000; n++)
    begin
      @(negedge ref_clk_in);
      if (irq_out === 1'b1)
        break;
    end
    t = cyc;
    o = timer_out_pin_out;
    if (n == 2000)
    begin
      num_errors++;
      report_and_stop;
    end
    @(posedge ref_clk_in);
  endtask : wait_irq

  task pin(input logic v);
    timer_in_pin_in <= v;
    repeat (6) @(posedge ref_clk_in);
  endtask : pin

  initial
  begin
    repeat (10) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    @(posedge ref_clk_in);
    rchk("ctrl reset", 8'h00, 32'h0);
    rchk("count reset", 8'h04, 32'h1);
    rchk("reload reset", 8'h08, 32'h0);
    rchk("unmapped", 8'h10, 32'h0);
    $display("test reset done");

    run(1'b1, 1'b0, 3'h0, 2'h0, 16'h0001, 16'h0005);
    wait_irq(t0, o0);
    base = t0 - ts;
    k = 0;
    repeat (6)
    begin
      @(negedge ref_clk_in);
      k += int'(timer_out_pin_out === 1'b1);
    end
    @(posedge ref_clk_in);
    check("oneshot pulse", 32'h1, k);
    rchk("oneshot count", 8'h04, 32'h1);
    rchk("oneshot ctrl", 8'h00, 32'h80);
    run(1'b1, 1'b0, 3'h0, 2'h0, 16'h0003, 16'h0005);
    wait_irq(t0, o0);
    check("oneshot time", 32'h2, base - (t0 - ts));
    run(1'b0, 1'b1, 3'h0, 2'h0, 16'h0001, 16'h0005);
    wait_irq(t0, o0);
    check("oneshot level", 32'h1, o0);
    $display("test oneshot done");

    foreach (pes[i])
    begin
      run(1'b1, 1'b0, pes[i][2:0], 2'h1, 16'h0002, 16'h0003);
      wait_irq(t0, o0);
      wait_irq(t1, o1);
      check("cont period", 3 << pes[i], t1 - t0);
      check("cont out", 32'h1, {o0, o1});
    end
    run(1'b0, 1'b0, 3'h0, 2'h1, 16'hFFFF, 16'h0001);
    wait_irq(t0, o0);
    check("wrap time", base - 2, t0 - ts);
    $display("test continuous done");

    run(1'b1, 1'b1, 3'h0, 2'h2, 16'h0001, 16'h0003);
    check("counter level", 32'h1, timer_out_pin_out);
    k = nirq;
    pin(1'b1);
    pin(1'b0);
    rchk("count edge", 8'h04, 32'h2);
    pin(1'b1);
    pin(1'b0);
    rchk("count match", 8'h04, 32'h3);
    rchk("status", 8'h0C, 32'h3);
    check("counter irq", 32'h1, nirq - k);
    check("counter out", 32'h0, timer_out_pin_out);
    pin(1'b1);
    rchk("count restart", 8'h04, 32'h1);
    pin(1'b0);
    run(1'b0, 1'b0, 3'h0, 2'h2, 16'h0001, 16'h0009);
    pin(1'b1);
    rchk("fall ignore rise", 8'h04, 32'h1);
    pin(1'b0);
    rchk("fall counted", 8'h04, 32'h2);
    $display("test counter done");
    report_and_stop;
  end
endmodule : test_reloadable_timer_16bit
